//--- scu_top.sv
// system control unit: modes, clock select, peripheral gating, resets, system interrupt
// assumes event pins arrive asynchronously; i_wake_irq comes from the interrupt
// controller on i_clock; i_sys_rst is power-on only, so reset causes survive o_dev_rst
`timescale 1ns/10ps
module scu_top
  import scu_pkg::*;
#(
  parameter logic [31:0] MEM_INFO  = 32'h0000_0000,
  parameter logic [31:0] PER_INFO  = 32'h0000_0000,
  parameter logic [31:0] PIN_INFO  = 32'h0000_0000
)(
  input  wire logic                i_clock,
  input  wire logic                i_sys_rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [SCU_NPIN-1:0] i_pin_events,
  input  wire logic                i_wake_irq,
  output logic                     o_cpu_clk_en,
  output logic                     o_pll_en,
  output logic [2:0]               o_sysclk_sel,
  output logic [1:0]               o_pll_ref_sel,
  output logic                     o_fail_ref_iosc,
  output logic [SCU_NPER-1:0]      o_periph_clk_en,
  output logic [SCU_NPER-1:0]      o_periph_alt_clk,
  output logic [SCU_NPER-1:0]      o_periph_rst,
  output logic                     o_dev_rst,
  output logic                     o_irq
);

  scu_state_t q;
  scu_state_t d;

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= SCU_INFOPIN);
  endfunction : mapped

  function automatic logic [31:0] w1c(input logic [31:0] v, input logic [31:0] m);
    w1c = v & ~m;
  endfunction : w1c

  logic                  acc;
  logic                  wr_go;
  logic                  rd_go;
  logic                  sw_go;
  logic [SCU_NPIN-1:0]   rise;
  logic [SCU_NINT-1:0]   int_shown;
  logic [SCU_NCAUSE-1:0] cause_ev;
  logic [31:0]           rd_mux;

  assign acc   = psel & penable;
  assign wr_go = acc & q.ack & pwrite;
  assign rd_go = acc & q.ack & ~pwrite;
  assign sw_go = wr_go & (paddr == SCU_SWRST) & pwdata[0];
  // only the second stage feeds logic
  assign rise  = q.sync2 & ~q.prev;
  // masked view selected by a control bit
  assign int_shown = q.clk_cfg[SCU_CF_MSKSEL] ? (q.int_raw & q.int_mask) : q.int_raw;
  // causes: vin low, ldo low, external, software, watchdog, main osc fail
  assign cause_ev = {q.sync2[3], q.sync2[8], sw_go, q.sync2[7], q.sync2[5], q.sync2[4]};

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      SCU_CLKCFG:  rd_mux = {24'h00_0000, q.clk_cfg};
      SCU_INTMASK: rd_mux = {25'h000_0000, q.int_mask};
      SCU_INTSTAT: rd_mux = {25'h000_0000, int_shown};
      SCU_RSTCAUS: rd_mux = {26'h000_0000, q.rst_cause};
      SCU_SLEEP:   rd_mux = {30'h0000_0000, q.mode};
      SCU_RUNEN:   rd_mux = q.run_en;
      SCU_SLPEN:   rd_mux = q.slp_en;
      SCU_DSLPEN:  rd_mux = q.dslp_en;
      SCU_PRST:    rd_mux = q.prst;
      SCU_ALTEN:   rd_mux = q.alt_en;
      SCU_INFOMEM: rd_mux = MEM_INFO;
      SCU_INFOPER: rd_mux = PER_INFO;
      SCU_INFOPIN: rd_mux = PIN_INFO;
      default:     rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    d       = q;
    d.sync1 = i_pin_events;
    d.sync2 = q.sync1;
    d.prev  = q.sync2;
    // one wait state so read data leaves a flip-flop
    d.ack   = acc & ~q.ack;
    if (acc && !q.ack)
    begin
      d.rdata = rd_mux;
    end
    if (wr_go)
    begin
      case (paddr)
        SCU_CLKCFG:  d.clk_cfg = pwdata[7:0];
        SCU_INTMASK: d.int_mask = pwdata[SCU_NINT-1:0];
        SCU_INTCLR:  d.int_raw = SCU_NINT'(w1c(32'(q.int_raw), pwdata));
        SCU_RSTCAUS: d.rst_cause = SCU_NCAUSE'(w1c(32'(q.rst_cause), pwdata));
        SCU_RUNEN:   d.run_en = pwdata;
        SCU_SLPEN:   d.slp_en = pwdata;
        SCU_DSLPEN:  d.dslp_en = pwdata;
        SCU_PRST:    d.prst = pwdata;
        SCU_ALTEN:   d.alt_en = pwdata;
        default:     d.rst_cnt = q.rst_cnt;
      endcase
    end
    // a read clears exactly the bits it returned
    if (rd_go && paddr == SCU_INTSTAT)
    begin
      d.int_raw = q.int_raw & ~q.rdata[SCU_NINT-1:0];
    end
    // sets land after clears so a same-cycle event is kept
    d.int_raw   = d.int_raw | rise[SCU_NINT-1:0];
    d.rst_cause = d.rst_cause | cause_ev;
    if (|cause_ev)
    begin
      d.rst_cnt = SCU_RST_CYC;
    end
    else if (q.rst_cnt != 8'h00)
    begin
      d.rst_cnt = q.rst_cnt - 8'h01;
    end
    case (q.mode)
      SCU_RUN:
      begin
        if (wr_go && paddr == SCU_SLEEP && pwdata[SCU_SL_DEEP])
        begin
          d.mode = SCU_DEEPSLEEP;
        end
        else if (wr_go && paddr == SCU_SLEEP && pwdata[SCU_SL_SLEEP])
        begin
          d.mode = SCU_SLEEPING;
        end
      end
      SCU_SLEEPING, SCU_DEEPSLEEP:
      begin
        if (i_wake_irq || o_irq)
        begin
          d.mode = SCU_RUN;
        end
      end
      default: d.mode = SCU_RUN;
    endcase
    // a device reset always lands the cpu back in run
    if (|cause_ev)
    begin
      d.mode = SCU_RUN;
    end
  end

  always_ff @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      q           <= '0;
      q.mode      <= SCU_RUN;
      q.clk_cfg   <= SCU_CLKCFG_RST;
      q.run_en    <= SCU_RUNEN_RST;
      q.rst_cnt   <= SCU_RST_CYC;
    end
    else
    begin
      q <= d;
    end
  end

  assign prdata  = q.rdata;
  assign pready  = q.ack;
  assign pslverr = q.ack & ~mapped(paddr);

  // cpu clock only in run; sleep leaves the source mux alone
  assign o_cpu_clk_en = (q.mode == SCU_RUN);
  // deep sleep falls back to the crystal, pll idle
  assign o_pll_en = (q.mode != SCU_DEEPSLEEP) && (q.clk_cfg[2:0] == SCU_SRC_PLL);
  assign o_sysclk_sel = (q.mode == SCU_DEEPSLEEP) ? SCU_SRC_MOSC : q.clk_cfg[2:0];
  assign o_pll_ref_sel = q.clk_cfg[SCU_CF_REF +: 2];
  assign o_fail_ref_iosc = q.clk_cfg[SCU_CF_FDIOSC];

  always_comb
  begin
    case (q.mode)
      SCU_SLEEPING:  o_periph_clk_en = q.slp_en;
      SCU_DEEPSLEEP: o_periph_clk_en = q.dslp_en;
      default:       o_periph_clk_en = q.run_en;
    endcase
  end

  // alt clock keeps baud-type timing steady across deep sleep
  assign o_periph_alt_clk = q.alt_en;
  assign o_periph_rst     = q.prst;
  assign o_dev_rst        = (q.rst_cnt != 8'h00);
  assign o_irq            = |(q.int_raw & q.int_mask);

  property p_sleep_cpu;
    @(posedge i_clock) disable iff (i_sys_rst)
    (q.mode == SCU_SLEEPING) |-> (!o_cpu_clk_en && o_sysclk_sel == q.clk_cfg[2:0]);
  endproperty
  a_sleep_cpu: assert property (p_sleep_cpu) else $error("sleep changed clocks");

  property p_deep_clk;
    @(posedge i_clock) disable iff (i_sys_rst)
    (q.mode == SCU_DEEPSLEEP) |-> (!o_pll_en && !o_cpu_clk_en && o_sysclk_sel == SCU_SRC_MOSC);
  endproperty
  a_deep_clk: assert property (p_deep_clk) else $error("deep sleep clocks wrong");

  property p_wake;
    @(posedge i_clock) disable iff (i_sys_rst)
    (q.mode != SCU_RUN && i_wake_irq) |=> (q.mode == SCU_RUN && o_cpu_clk_en);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on interrupt");

  property p_rst_event;
    @(posedge i_clock) disable iff (i_sys_rst)
    $rose(q.sync2[8]) |=> (o_dev_rst && q.rst_cause[4]) [*8];
  endproperty
  a_rst_event: assert property (p_rst_event) else $error("watchdog did not reset");

  property p_cause_keep;
    @(posedge i_clock) disable iff (i_sys_rst)
    (q.rst_cause[0] && !(wr_go && paddr == SCU_RSTCAUS && pwdata[0])) |=> q.rst_cause[0];
  endproperty
  a_cause_keep: assert property (p_cause_keep) else $error("reset cause lost");

  property p_sleep_set;
    @(posedge i_clock) disable iff (i_sys_rst)
    (q.mode == SCU_SLEEPING) |-> (o_periph_clk_en == q.slp_en);
  endproperty
  a_sleep_set: assert property (p_sleep_set) else $error("sleep enable set not applied");

  property p_int_raise;
    @(posedge i_clock) disable iff (i_sys_rst)
    ($rose(q.sync2[0]) && q.int_mask[0]) |=> (o_irq && q.int_raw[0]);
  endproperty
  a_int_raise: assert property (p_int_raise) else $error("pll lock irq missing");

  property p_int_gate;
    @(posedge i_clock) disable iff (i_sys_rst)
    (q.int_mask == '0) |-> !o_irq;
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("masked source raised irq");

  property p_swrst;
    @(posedge i_clock) disable iff (i_sys_rst)
    sw_go |=> (o_dev_rst && q.rst_cause[SCU_RC_SW] && q.rst_cnt == SCU_RST_CYC);
  endproperty
  a_swrst: assert property (p_swrst) else $error("software reset ignored");

  property p_clr_named;
    @(posedge i_clock) disable iff (i_sys_rst)
    (wr_go && paddr == SCU_INTCLR && !pwdata[1] && q.int_raw[1]) |=> q.int_raw[1];
  endproperty
  a_clr_named: assert property (p_clr_named) else $error("unnamed flag cleared");

  property p_run_set;
    @(posedge i_clock) disable iff (i_sys_rst)
    (q.mode == SCU_RUN) |-> (o_cpu_clk_en && o_periph_clk_en == q.run_en);
  endproperty
  a_run_set: assert property (p_run_set) else $error("run enable set not applied");

  property p_deep_set;
    @(posedge i_clock) disable iff (i_sys_rst)
    (q.mode == SCU_DEEPSLEEP) |-> (o_periph_clk_en == q.dslp_en);
  endproperty
  a_deep_set: assert property (p_deep_set) else $error("deep enable set not applied");

  property p_sleep_entry;
    @(posedge i_clock) disable iff (i_sys_rst)
    (q.mode == SCU_RUN && wr_go && paddr == SCU_SLEEP && pwdata[SCU_SL_SLEEP]
      && !pwdata[SCU_SL_DEEP] && cause_ev == '0) |=> (q.mode == SCU_SLEEPING);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep request ignored");

  // flags drop only on an apb clear or a status read
  property p_flag_hold;
    @(posedge i_clock) disable iff (i_sys_rst)
    (q.int_raw[0] && !wr_go && !rd_go) |=> q.int_raw[0];
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped uncleared");

endmodule : scu_top

//--- scu_pkg.sv
// system control unit: register map, field layout, reset values, timing, state types
// assumes a 250 MHz system clock and an apb slave with 32-bit data
package scu_pkg;
  localparam int unsigned SCU_CLK_NS = 4;
  localparam int unsigned SCU_RST_NS = 1000;
  localparam logic [7:0]  SCU_RST_CYC = 8'((SCU_RST_NS + SCU_CLK_NS - 1) / SCU_CLK_NS);
  localparam int unsigned SCU_NPER   = 32;
  localparam int unsigned SCU_NINT   = 7;
  localparam int unsigned SCU_NCAUSE = 6;
  localparam int unsigned SCU_NPIN   = 9;
  // byte offsets
  localparam logic [11:0] SCU_CLKCFG  = 12'h000;
  localparam logic [11:0] SCU_INTMASK = 12'h004;
  localparam logic [11:0] SCU_INTSTAT = 12'h008;
  localparam logic [11:0] SCU_INTCLR  = 12'h00C;
  localparam logic [11:0] SCU_RSTCAUS = 12'h010;
  localparam logic [11:0] SCU_SWRST   = 12'h014;
  localparam logic [11:0] SCU_SLEEP   = 12'h018;
  localparam logic [11:0] SCU_RUNEN   = 12'h01C;
  localparam logic [11:0] SCU_SLPEN   = 12'h020;
  localparam logic [11:0] SCU_DSLPEN  = 12'h024;
  localparam logic [11:0] SCU_PRST    = 12'h028;
  localparam logic [11:0] SCU_ALTEN   = 12'h02C;
  localparam logic [11:0] SCU_INFOMEM = 12'h030;
  localparam logic [11:0] SCU_INFOPER = 12'h034;
  localparam logic [11:0] SCU_INFOPIN = 12'h038;
  // clock source codes
  localparam logic [2:0]  SCU_SRC_EXT   = 3'h0;
  localparam logic [2:0]  SCU_SRC_MOSC  = 3'h1;
  localparam logic [2:0]  SCU_SRC_IOSC  = 3'h2;
  localparam logic [2:0]  SCU_SRC_PREC  = 3'h3;
  localparam logic [2:0]  SCU_SRC_PLL   = 3'h4;
  // clkcfg fields
  localparam int unsigned SCU_CF_SRC    = 0;
  localparam int unsigned SCU_CF_REF    = 3;
  localparam int unsigned SCU_CF_FDIOSC = 6;
  localparam int unsigned SCU_CF_MSKSEL = 7;
  localparam logic [7:0]  SCU_CLKCFG_RST = 8'h01;
  // sleep register bits, reset cause bits
  localparam int unsigned SCU_SL_SLEEP = 0;
  localparam int unsigned SCU_SL_DEEP  = 1;
  localparam int unsigned SCU_RC_SW    = 3;
  localparam logic [SCU_NPER-1:0] SCU_RUNEN_RST = 32'h0000_0000;

  typedef enum logic [1:0] {SCU_RUN, SCU_SLEEPING, SCU_DEEPSLEEP} scu_mode_t;

  typedef struct packed {
    logic [SCU_NPIN-1:0]   sync1;
    logic [SCU_NPIN-1:0]   sync2;
    logic [SCU_NPIN-1:0]   prev;
    scu_mode_t             mode;
    logic [7:0]            clk_cfg;
    logic [SCU_NINT-1:0]   int_raw;
    logic [SCU_NINT-1:0]   int_mask;
    logic [SCU_NCAUSE-1:0] rst_cause;
    logic [SCU_NPER-1:0]   run_en;
    logic [SCU_NPER-1:0]   slp_en;
    logic [SCU_NPER-1:0]   dslp_en;
    logic [SCU_NPER-1:0]   prst;
    logic [SCU_NPER-1:0]   alt_en;
    logic [7:0]            rst_cnt;
    logic                  ack;
    logic [31:0]           rdata;
  } scu_state_t;
endpackage : scu_pkg

//--- scu_top_test.sv
// testbench for the system control unit: apb master, event pins, wake input
// assumes scu_top with its apb slave answering pready two cycles into the access
`timescale 1ns/10ps
module scu_top_test
  import scu_pkg::*;
;
  logic                i_clock = 1'b0;
  logic                i_sys_rst = 1'b1;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [11:0]         paddr = 12'h000;
  logic [31:0]         pwdata = 32'h0000_0000;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [SCU_NPIN-1:0] i_pin_events = 9'h000;
  logic                i_wake_irq = 1'b0;
  logic                o_cpu_clk_en;
  logic                o_pll_en;
  logic [2:0]          o_sysclk_sel;
  logic [1:0]          o_pll_ref_sel;
  logic                o_fail_ref_iosc;
  logic [SCU_NPER-1:0] o_periph_clk_en;
  logic [SCU_NPER-1:0] o_periph_alt_clk;
  logic [SCU_NPER-1:0] o_periph_rst;
  logic                o_dev_rst;
  logic                o_irq;
  logic [31:0]         rdv;
  logic                errv;
  int                  error_cnt = 0;
  int                  check_count = 0;
  int                  cyc = 0;

  scu_top #(.MEM_INFO(32'h0000_1234), .PER_INFO(32'h0000_00FF), .PIN_INFO(32'h0000_0021))
  scu_top_inst (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_pin_events(i_pin_events), .i_wake_irq(i_wake_irq),
    .o_cpu_clk_en(o_cpu_clk_en), .o_pll_en(o_pll_en), .o_sysclk_sel(o_sysclk_sel),
    .o_pll_ref_sel(o_pll_ref_sel), .o_fail_ref_iosc(o_fail_ref_iosc),
    .o_periph_clk_en(o_periph_clk_en), .o_periph_alt_clk(o_periph_alt_clk),
    .o_periph_rst(o_periph_rst), .o_dev_rst(o_dev_rst), .o_irq(o_irq));

  initial
  begin
    forever #2 i_clock = ~i_clock;
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // hang guard, well above the fewer than two thousand cycles the run needs
  always @(posedge i_clock)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // request held until the edge that samples pready high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    do
    begin
      @(posedge i_clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk("pready", 32'h1, 32'h0);
    rdv = prdata;
    errv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // callers look only after the answering edge has landed
    @(posedge i_clock);
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, e, rdv);
  endtask : rd

  task pulse(input logic [8:0] m, input int len);
    @(posedge i_clock);
    i_pin_events <= m;
    repeat (len) @(posedge i_clock);
    i_pin_events <= 9'h000;
    repeat (6) @(posedge i_clock);
  endtask : pulse

  task wait_rst_done;
    int n;
    n = 0;
    while (o_dev_rst !== 1'b0 && n < 400)
    begin
      @(posedge i_clock);
      n++;
    end
    chk("dev_rst_end", 32'h0, {31'h0, o_dev_rst});
  endtask : wait_rst_done

  task t_reset;
    repeat (240) @(posedge i_clock);
    chk("dev_rst_hold", 32'h1, {31'h0, o_dev_rst});
    repeat (20) @(posedge i_clock);
    chk("dev_rst_low", 32'h0, {31'h0, o_dev_rst});
    rd(SCU_CLKCFG, 32'h0000_0001, "clkcfg_rst");
    rd(SCU_INFOMEM, 32'h0000_1234, "info_mem");
    rd(SCU_INFOPER, 32'h0000_00FF, "info_per");
    wr(SCU_INFOPIN, 32'hFFFF_FFFF);
    rd(SCU_INFOPIN, 32'h0000_0021, "info_pin_ro");
    apb(1'b0, 12'h03C, 32'h0000_0000);
    chk("unmapped_err", 32'h1, {31'h0, errv});
    apb(1'b1, 12'h002, 32'h0000_0000);
    chk("misaligned_err", 32'h1, {31'h0, errv});
  endtask : t_reset

  task t_sleep;
    wr(SCU_CLKCFG, 32'h0000_0054);
    wr(SCU_RUNEN, 32'h0000_00A5);
    wr(SCU_SLPEN, 32'h0000_000F);
    wr(SCU_DSLPEN, 32'h0000_00F0);
    wr(SCU_PRST, 32'h0000_0003);
    wr(SCU_ALTEN, 32'h0000_0080);
    @(posedge i_clock);
    chk("pll_src", {29'h0, SCU_SRC_PLL}, {29'h0, o_sysclk_sel});
    chk("pll_ref", 32'h2, {30'h0, o_pll_ref_sel});
    chk("fail_ref", 32'h1, {31'h0, o_fail_ref_iosc});
    chk("run_en", 32'h0000_00A5, o_periph_clk_en);
    chk("prst", 32'h0000_0003, o_periph_rst);
    chk("alt_clk", 32'h0000_0080, o_periph_alt_clk);
    wr(SCU_SLEEP, 32'h0000_0001);
    @(posedge i_clock);
    chk("slp_cpu", 32'h0, {31'h0, o_cpu_clk_en});
    chk("slp_src", {29'h0, SCU_SRC_PLL}, {29'h0, o_sysclk_sel});
    chk("slp_en", 32'h0000_000F, o_periph_clk_en);
    i_wake_irq <= 1'b1;
    @(posedge i_clock);
    i_wake_irq <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk("wake_cpu", 32'h1, {31'h0, o_cpu_clk_en});
    wr(SCU_SLEEP, 32'h0000_0002);
    @(posedge i_clock);
    chk("dslp_cpu", 32'h0, {31'h0, o_cpu_clk_en});
    chk("dslp_pll", 32'h0, {31'h0, o_pll_en});
    chk("dslp_src", {29'h0, SCU_SRC_MOSC}, {29'h0, o_sysclk_sel});
    chk("dslp_en", 32'h0000_00F0, o_periph_clk_en);
    chk("dslp_alt", 32'h0000_0080, o_periph_alt_clk);
    i_wake_irq <= 1'b1;
    @(posedge i_clock);
    i_wake_irq <= 1'b0;
    repeat (2) @(posedge i_clock);
    chk("dwake_pll", 32'h1, {31'h0, o_pll_en});
    chk("dwake_en", 32'h0000_00A5, o_periph_clk_en);
  endtask : t_sleep

  task t_irq;
    wr(SCU_INTMASK, 32'h0000_0001);
    pulse(9'h002, 3);
    chk("masked_off", 32'h0, {31'h0, o_irq});
    pulse(9'h001, 3);
    chk("irq_on", 32'h1, {31'h0, o_irq});
    rd(SCU_INTSTAT, 32'h0000_0003, "raw_stat");
    chk("irq_clr_rd", 32'h0, {31'h0, o_irq});
    pulse(9'h007, 3);
    wr(SCU_CLKCFG, 32'h0000_00D4);
    wr(SCU_INTCLR, 32'h0000_0004);
    chk("irq_keep", 32'h1, {31'h0, o_irq});
    rd(SCU_INTSTAT, 32'h0000_0001, "masked_stat");
    rd(SCU_INTSTAT, 32'h0000_0000, "stat_empty");
    wr(SCU_CLKCFG, 32'h0000_0054);
    rd(SCU_INTSTAT, 32'h0000_0002, "raw_keep");
    pulse(9'h040, 3);
    wr(SCU_INTMASK, 32'h0000_007F);
    chk("irq_pllfail", 32'h1, {31'h0, o_irq});
    wr(SCU_INTCLR, 32'h0000_007F);
    chk("irq_w1c", 32'h0, {31'h0, o_irq});
  endtask : t_irq

  task t_cause;
    wr(SCU_RSTCAUS, 32'h0000_003F);
    pulse(9'h080, 2);
    chk("ext_rst", 32'h1, {31'h0, o_dev_rst});
    wait_rst_done();
    rd(SCU_RSTCAUS, 32'h0000_0004, "cause_ext");
    wr(SCU_SWRST, 32'h0000_0001);
    repeat (2) @(posedge i_clock);
    chk("sw_rst", 32'h1, {31'h0, o_dev_rst});
    wait_rst_done();
    rd(SCU_RSTCAUS, 32'h0000_000C, "cause_sw");
    wr(SCU_RSTCAUS, 32'h0000_0008);
    rd(SCU_RSTCAUS, 32'h0000_0004, "cause_w1c");
    pulse(9'h100, 2);
    wait_rst_done();
    rd(SCU_RSTCAUS, 32'h0000_0014, "cause_wdt");
    pulse(9'h010, 2);
    chk("vin_irq", 32'h1, {31'h0, o_irq});
    wait_rst_done();
    rd(SCU_RSTCAUS, 32'h0000_0015, "cause_vin");
  endtask : t_cause

  // cause scenario last: a device reset may disturb the other settings
  initial
  begin
    repeat (10) @(posedge i_clock);
    i_sys_rst <= 1'b0;
    t_reset();
    t_sleep();
    t_irq();
    t_cause();
    print_verdict();
  end
endmodule : scu_top_test
